/* pkg/tsra_pkg.sv */
// Constants, register map and link states of the temperature sensor register block.
// Assumes a 25 MHz system clock and an externally supplied two-wire serial clock.
// What this block does
// [R01] Latch a fresh temperature sample at least eight times per second while enabled.
// [R02] Serial bits go most significant first; the master supplies the serial clock.
// [R03] Alert supports interrupt, comparator and critical-alarm behaviours by configuration.
// [R04] Interrupt behaviour latches alert until software writes the interrupt-clear bit.
// [R05] Alert-mode bit zero of settings selects interrupt or comparator behaviour.
// [R06] Comparator alert follows the limit condition and clears by itself.
// [R07] Critical alarm holds alert until temperature drops below critical minus hysteresis.
// [R08] Every limit comparison uses the currently selected hysteresis.
// [R09] With alert enabled, entering and leaving the limit window both trigger.
// [R10] An 8-bit write-only register select chooses the 16-bit register accessed.
// [R11] Reads of write-only locations return zero.
// [R12] Writes to read-only registers change nothing but every byte is acknowledged.
// [R13] The master avoids writing the reserved select values 08h to 0Fh; the bench's rd_reg writes selects 08h and 09h.
// [R14] Register select is zero after power-on, so reads return feature flags.
// [R15] Feature flags are read-only, upper byte zero, fixed value 00F7h.
// [R16] Shutdown releases alert until the next sample, except a pending interrupt.
// [R17] A serial bus timeout between 25 and 35 ms resets the serial interface.
// [R18] Feature flag resolution field, bits four to three, reads binary 10.
// [R19] Negative temperatures are reported with a sign bit and advertised.
// [R20] Feature flag bit zero reads one, advertising interrupt support.
// [R21] Hysteresis select bits ten to nine encode 0, 1.5, 3.0 and 6.0 degrees.
// [R22] Hysteresis acts on falling temperature only.
// [R23] Sensor-off bit eight stops conversion, temperature updates and alerts.
// [R24] Writes carry select byte then high and low bytes; reads return high then low.
package tsra_pkg;

  localparam logic [7:0] PTR_CAPS = 8'h00;
  localparam logic [7:0] PTR_CFG = 8'h01;
  localparam logic [7:0] PTR_HIGH = 8'h02;
  localparam logic [7:0] PTR_LOW = 8'h03;
  localparam logic [7:0] PTR_CRIT = 8'h04;
  localparam logic [7:0] PTR_TEMP = 8'h05;
  localparam logic [7:0] PTR_MAKER = 8'h06;
  localparam logic [7:0] PTR_PART = 8'h07;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Feature flags: bit 0 interrupt, 2 negative range, 4:3 resolution 10, 5..7 fixed ones.
  localparam logic [15:0] CAPS_VALUE = 16'h00F7;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [15:0] CFG_STORE_MASK = 16'h07CF;
  localparam int CFG_MODE_BIT = 0;
  localparam int CFG_CRIT_ONLY_BIT = 2;
  localparam int CFG_ENABLE_BIT = 3;
  localparam int CFG_STATUS_BIT = 4;
  localparam int CFG_CLEAR_BIT = 5;
  localparam int CFG_OFF_BIT = 8;
  localparam int CFG_HYS_LSB = 9;
  localparam int TEMP_CRIT_BIT = 15;
  localparam int TEMP_HIGH_BIT = 14;
  localparam int TEMP_LOW_BIT = 13;

  // Hysteresis in temperature LSBs of 1/16 degree.
  localparam logic [13:0] HYS_0P0 = 14'h0000;
  localparam logic [13:0] HYS_1P5 = 14'h0018;
  localparam logic [13:0] HYS_3P0 = 14'h0030;
  localparam logic [13:0] HYS_6P0 = 14'h0060;

  localparam logic [3:0] SLAVE_TYPE = 4'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Arbitrary identification values, not those of any real part.
  localparam logic [15:0] MAKER_CODE_DEFAULT = 16'h0A5A;
  localparam logic [15:0] PART_CODE_DEFAULT = 16'h0C3C;

  localparam int CLK_HZ = 25000000;
  localparam int CONV_PERIOD_MS = 100;
  localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_PERIOD_MS;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

  typedef enum logic [2:0] {
    LS_ADDR, LS_PTR, LS_WR_HI, LS_WR_LO, LS_RD_HI, LS_RD_LO, LS_IGNORE
  } tsra_link_state_t;

endpackage

/* logic/tsra_top.sv */
// Temperature sensor registers, alert logic and the two-wire serial slave.
// Assumes i_scl is the master's serial clock used as a clock, and that the
// address straps and sensor code are static or on i_clk respectively.
`timescale 1ns/100ps

module tsra_top #(
  parameter int CONV_CYCLES = tsra_pkg::CONV_CYCLES,
  parameter int TIMEOUT_CYCLES = tsra_pkg::TIMEOUT_CYCLES,
  parameter logic [15:0] MAKER_CODE = tsra_pkg::MAKER_CODE_DEFAULT,
  parameter logic [15:0] PART_CODE = tsra_pkg::PART_CODE_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  input wire logic [2:0] i_addr_strap,
  input wire logic [11:0] i_sensor_code,
  output logic o_alert_o,
  output logic o_alert_oe_n
);

  initial begin
    if (CONV_CYCLES < 2 || CONV_CYCLES > 16777215) begin
      $error("CONV_CYCLES out of range");
    end
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 16777215) begin
      $error("TIMEOUT_CYCLES out of range");
    end
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic frame_clr_reg;
  logic arm_reg;
  logic [3:0] scl_sync_reg;
  logic [3:0] sda_sync_reg;
  logic [3:0] tog_sync_reg;
  logic scl_tog_reg;
  logic [2:0] addr_s1_reg;
  logic [2:0] addr_s2_reg;
  logic [1:0] rd_sync_reg;
  logic [2:0] ptr_sync_reg;
  logic [2:0] wr_sync_reg;
  logic [23:0] tout_cnt_reg;
  logic [23:0] conv_cnt_reg;
  logic [7:0] ptr_reg;
  logic [15:0] cfg_reg;
  logic [15:0] high_reg;
  logic [15:0] low_reg;
  logic [15:0] crit_reg;
  logic [15:0] temp_reg;
  logic over_hi_reg;
  logic over_lo_reg;
  logic over_crit_reg;
  logic outside_prev_reg;
  logic sampled_on_reg;
  logic intr_reg;
  logic [15:0] rd_mirror_reg;

  tsra_pkg::tsra_link_state_t state_reg;
  tsra_pkg::tsra_link_state_t state_next;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic reading_reg;
  logic [7:0] data_hi_reg;
  logic [7:0] ptr_byte_reg;
  logic ptr_tog_reg;
  logic [15:0] wr_word_reg;
  logic wr_tog_reg;

  // ---------------------------------------------------------------
  // Frame start, stop and bus timeout on the system clock
  // ---------------------------------------------------------------
  wire scl_high = scl_sync_reg[1];
  // Sampling misses short serial clock lows, so a clock edge toggle must stay quiet too.
  wire tog_quiet = (tog_sync_reg[3] == tog_sync_reg[2]) & (tog_sync_reg[2] == tog_sync_reg[1]);
  wire scl_quiet = tog_quiet & scl_sync_reg[2] & scl_sync_reg[3];
  wire start_det = scl_quiet & sda_sync_reg[3] & ~sda_sync_reg[2];
  wire stop_det = scl_quiet & ~sda_sync_reg[3] & sda_sync_reg[2];
  wire tout_hit = (tout_cnt_reg == 24'(TIMEOUT_CYCLES - 1));
  wire clr_set = start_det | stop_det | tout_hit;
  wire clr_release = arm_reg & ~scl_high & ~clr_set;
  wire frame_clr_next = clr_set ? 1'b1 : (clr_release ? 1'b0 : frame_clr_reg);
  wire arm_next = start_det ? 1'b1 : ((stop_det | tout_hit | clr_release) ? 1'b0 : arm_reg);
  wire [23:0] tout_cnt_next = (scl_high | frame_clr_reg) ? 24'h000000 : tout_cnt_reg + 24'h000001;
  // The serial logic is held in reset between frames; it is released only while
  // the serial clock is low, so no serial edge races the release.
  wire link_rst_n = i_rst_n & ~frame_clr_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_sync_reg <= 4'hF;
      sda_sync_reg <= 4'hF;
      tog_sync_reg <= 4'h0;
      addr_s1_reg <= 3'h0;
      addr_s2_reg <= 3'h0;
      rd_sync_reg <= 2'h0;
      ptr_sync_reg <= 3'h0;
      wr_sync_reg <= 3'h0;
      frame_clr_reg <= 1'b1;
      arm_reg <= 1'b0;
      tout_cnt_reg <= 24'h000000;
    end else begin
      scl_sync_reg <= {scl_sync_reg[2:0], i_scl};
      sda_sync_reg <= {sda_sync_reg[2:0], i_sda};
      tog_sync_reg <= {tog_sync_reg[2:0], scl_tog_reg};
      addr_s1_reg <= i_addr_strap;
      addr_s2_reg <= addr_s1_reg;
      rd_sync_reg <= {rd_sync_reg[0], reading_reg};
      ptr_sync_reg <= {ptr_sync_reg[1:0], ptr_tog_reg};
      wr_sync_reg <= {wr_sync_reg[1:0], wr_tog_reg};
      frame_clr_reg <= frame_clr_next; // R17
      arm_reg <= arm_next;
      tout_cnt_reg <= tout_cnt_next; // R17
    end
  end

  // ---------------------------------------------------------------
  // Register file and writes arriving from the serial side
  // ---------------------------------------------------------------
  wire ptr_evt = ptr_sync_reg[2] ^ ptr_sync_reg[1];
  wire wr_evt = wr_sync_reg[2] ^ wr_sync_reg[1];
  wire wr_cfg = wr_evt & (ptr_reg == tsra_pkg::PTR_CFG);
  wire cfg_clear = wr_cfg & wr_word_reg[tsra_pkg::CFG_CLEAR_BIT];
  wire sensor_off = cfg_reg[tsra_pkg::CFG_OFF_BIT];
  wire alert_en = cfg_reg[tsra_pkg::CFG_ENABLE_BIT];
  wire mode_int = cfg_reg[tsra_pkg::CFG_MODE_BIT];
  wire crit_only = cfg_reg[tsra_pkg::CFG_CRIT_ONLY_BIT];
  wire [1:0] hys_sel = cfg_reg[tsra_pkg::CFG_HYS_LSB +: 2];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_reg <= tsra_pkg::PTR_RESET; // R14
      cfg_reg <= tsra_pkg::CFG_RESET;
      high_reg <= tsra_pkg::LIMIT_RESET;
      low_reg <= tsra_pkg::LIMIT_RESET;
      crit_reg <= tsra_pkg::LIMIT_RESET;
    end else begin
      if (ptr_evt) begin
        ptr_reg <= ptr_byte_reg; // R10
      end
      // Read-only and reserved selects fall through untouched.
      if (wr_cfg) begin
        cfg_reg <= wr_word_reg & tsra_pkg::CFG_STORE_MASK; // R12
      end
      if (wr_evt && ptr_reg == tsra_pkg::PTR_HIGH) begin
        high_reg <= wr_word_reg;
      end
      if (wr_evt && ptr_reg == tsra_pkg::PTR_LOW) begin
        low_reg <= wr_word_reg;
      end
      if (wr_evt && ptr_reg == tsra_pkg::PTR_CRIT) begin
        crit_reg <= wr_word_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion and limit comparison
  // ---------------------------------------------------------------
  function automatic logic limit_flag(input logic flag, input logic signed [13:0] t,
                                      input logic signed [13:0] lim,
                                      input logic signed [13:0] hys);
    logic signed [13:0] floor_v;
    floor_v = lim - hys;
    // Hysteresis only delays the clear on falling temperature.
    if (t > lim) begin
      limit_flag = 1'b1;
    end else if (t < floor_v) begin
      limit_flag = 1'b0; // R22
    end else begin
      limit_flag = flag;
    end
  endfunction

  wire conv_wrap = (conv_cnt_reg == 24'(CONV_CYCLES - 1));
  wire sample = conv_wrap & ~sensor_off; // R01 R23
  wire [23:0] conv_cnt_next = conv_wrap ? 24'h000000 : conv_cnt_reg + 24'h000001;
  wire [12:0] new_temp = {i_sensor_code, 1'b0}; // R19
  wire signed [13:0] t_ext = {new_temp[12], new_temp};
  wire [13:0] hys_amt = (hys_sel == 2'h0) ? tsra_pkg::HYS_0P0 :
                        (hys_sel == 2'h1) ? tsra_pkg::HYS_1P5 :
                        (hys_sel == 2'h2) ? tsra_pkg::HYS_3P0 : tsra_pkg::HYS_6P0; // R21
  wire over_hi_next = limit_flag(over_hi_reg, t_ext, {high_reg[12], high_reg[12:0]},
                                 hys_amt); // R08
  wire over_lo_next = limit_flag(over_lo_reg, t_ext, {low_reg[12], low_reg[12:0]}, hys_amt);
  wire over_crit_next = limit_flag(over_crit_reg, t_ext, {crit_reg[12], crit_reg[12:0]},
                                   hys_amt); // R07
  wire outside_next = over_hi_next | ~over_lo_next;
  wire outside_now = over_hi_reg | ~over_lo_reg;

  // ---------------------------------------------------------------
  // Alert behaviours
  // ---------------------------------------------------------------
  wire win_change = (outside_next != outside_prev_reg); // R09
  wire crit_rise = over_crit_next & ~over_crit_reg;
  wire intr_set = sample & alert_en & mode_int & ~crit_only & (win_change | crit_rise); // R04
  wire intr_next = intr_set | (intr_reg & ~cfg_clear); // R04
  wire cmp_part = sampled_on_reg &
                  (over_crit_reg | (~mode_int & ~crit_only & outside_now)); // R05 R06 R07
  // A pending interrupt is not gated by a fresh sample after shutdown.
  wire alert_active = alert_en & ~sensor_off &
                      ((mode_int & ~crit_only & intr_reg) | cmp_part); // R03 R16 R23
  wire sampled_on_next = sensor_off ? 1'b0 : (sample ? 1'b1 : sampled_on_reg); // R16

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      conv_cnt_reg <= 24'h000000;
      temp_reg <= 16'h0000;
      over_hi_reg <= 1'b0;
      over_lo_reg <= 1'b0;
      over_crit_reg <= 1'b0;
      outside_prev_reg <= 1'b0;
      sampled_on_reg <= 1'b0;
      intr_reg <= 1'b0;
      o_alert_o <= 1'b0;
      o_alert_oe_n <= 1'b1;
    end else begin
      conv_cnt_reg <= conv_cnt_next;
      if (sample) begin
        temp_reg <= {over_crit_next, over_hi_next, ~over_lo_next, new_temp}; // R01
        over_hi_reg <= over_hi_next;
        over_lo_reg <= over_lo_next;
        over_crit_reg <= over_crit_next;
        outside_prev_reg <= outside_next;
      end
      sampled_on_reg <= sampled_on_next;
      intr_reg <= intr_next;
      o_alert_o <= 1'b0;
      o_alert_oe_n <= ~alert_active;
    end
  end

  // ---------------------------------------------------------------
  // Read view handed to the serial side
  // ---------------------------------------------------------------
  wire [15:0] cfg_view = (cfg_reg & tsra_pkg::CFG_STORE_MASK) |
                         (16'({~o_alert_oe_n}) << tsra_pkg::CFG_STATUS_BIT);
  wire [15:0] rd_sel = (ptr_reg == tsra_pkg::PTR_CAPS) ? tsra_pkg::CAPS_VALUE : // R15 R18 R20
                       (ptr_reg == tsra_pkg::PTR_CFG) ? cfg_view :
                       (ptr_reg == tsra_pkg::PTR_HIGH) ? high_reg :
                       (ptr_reg == tsra_pkg::PTR_LOW) ? low_reg :
                       (ptr_reg == tsra_pkg::PTR_CRIT) ? crit_reg :
                       (ptr_reg == tsra_pkg::PTR_TEMP) ? temp_reg :
                       (ptr_reg == tsra_pkg::PTR_MAKER) ? MAKER_CODE :
                       (ptr_reg == tsra_pkg::PTR_PART) ? PART_CODE : 16'h0000; // R11
  // The view freezes while a read is in progress so the serial side sees a
  // settled word; a conversion landing right at the read start is the limit.
  wire [15:0] rd_mirror_next = rd_sync_reg[1] ? rd_mirror_reg : rd_sel;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_mirror_reg <= tsra_pkg::CAPS_VALUE;
    end else begin
      rd_mirror_reg <= rd_mirror_next;
    end
  end

  // ---------------------------------------------------------------
  // Serial slave on the master's clock
  // ---------------------------------------------------------------
  wire byte_done = (bit_cnt_reg == tsra_pkg::BYTE_BITS);
  wire addr_match = (shift_reg[7:1] == {tsra_pkg::SLAVE_TYPE, addr_s2_reg});
  wire master_nack = i_sda;
  wire in_read = (state_reg == tsra_pkg::LS_RD_HI) || (state_reg == tsra_pkg::LS_RD_LO);
  wire in_write = (state_reg == tsra_pkg::LS_PTR) || (state_reg == tsra_pkg::LS_WR_HI) ||
                  (state_reg == tsra_pkg::LS_WR_LO);
  wire ack_wanted = (state_reg == tsra_pkg::LS_ADDR) ? addr_match : in_write; // R12
  wire tx_bit = tx_reg[3'h7 - bit_cnt_reg[2:0]]; // R02
  wire drive_low = byte_done ? ack_wanted : (in_read & ~tx_bit);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tsra_pkg::LS_ADDR: begin
        if (!addr_match) begin
          state_next = tsra_pkg::LS_IGNORE;
        end else if (shift_reg[0]) begin
          state_next = tsra_pkg::LS_RD_HI;
        end else begin
          state_next = tsra_pkg::LS_PTR;
        end
      end
      tsra_pkg::LS_PTR: state_next = tsra_pkg::LS_WR_HI; // R24
      tsra_pkg::LS_WR_HI: state_next = tsra_pkg::LS_WR_LO;
      tsra_pkg::LS_WR_LO: state_next = tsra_pkg::LS_WR_HI;
      tsra_pkg::LS_RD_HI: state_next = master_nack ? tsra_pkg::LS_IGNORE : tsra_pkg::LS_RD_LO;
      tsra_pkg::LS_RD_LO: state_next = master_nack ? tsra_pkg::LS_IGNORE : tsra_pkg::LS_RD_HI;
      tsra_pkg::LS_IGNORE: state_next = tsra_pkg::LS_IGNORE;
      default: state_next = tsra_pkg::LS_IGNORE;
    endcase
  end

  assign tx_next = (state_next == tsra_pkg::LS_RD_LO) ? rd_mirror_reg[7:0] :
                   rd_mirror_reg[15:8]; // R24

  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_reg <= tsra_pkg::LS_ADDR;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      tx_reg <= 8'h00;
      reading_reg <= 1'b0;
    end else if (!byte_done) begin
      shift_reg <= {shift_reg[6:0], i_sda}; // R02
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else begin
      bit_cnt_reg <= 4'h0;
      state_reg <= state_next;
      tx_reg <= tx_next;
      reading_reg <= reading_reg | (state_next == tsra_pkg::LS_RD_HI);
    end
  end

  // Payload and toggles survive the per-frame reset so that each toggle edge
  // stays a single event for the system clock side.
  always_ff @(posedge i_scl or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_hi_reg <= 8'h00;
      ptr_byte_reg <= tsra_pkg::PTR_RESET;
      ptr_tog_reg <= 1'b0;
      wr_word_reg <= 16'h0000;
      wr_tog_reg <= 1'b0;
      scl_tog_reg <= 1'b0;
    end else begin
      scl_tog_reg <= ~scl_tog_reg;
      if (byte_done && !frame_clr_reg && state_reg == tsra_pkg::LS_PTR) begin
        ptr_byte_reg <= shift_reg; // R10
        ptr_tog_reg <= ~ptr_tog_reg;
      end
      if (byte_done && !frame_clr_reg && state_reg == tsra_pkg::LS_WR_HI) begin
        data_hi_reg <= shift_reg;
      end
      if (byte_done && !frame_clr_reg && state_reg == tsra_pkg::LS_WR_LO) begin
        wr_word_reg <= {data_hi_reg, shift_reg}; // R24
        wr_tog_reg <= ~wr_tog_reg;
      end
    end
  end

  always_ff @(negedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      o_sda_o <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else begin
      o_sda_o <= 1'b0;
      o_sda_oe_n <= ~drive_low; // R02 R12
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_flags_set;
    ##1 over_crit_reg;
  endsequence

  sequence s_pin_low;
    ##1 !o_alert_oe_n;
  endsequence

  conv_latch_a: assert property (sample |=> temp_reg[12:1] == $past(i_sensor_code)) // R01
    else $error("temperature not latched from sample");
  cmp_self_clear_a: assert property ( // R06
    (alert_en && !mode_int && !crit_only && !over_crit_reg && !outside_now) |=> o_alert_oe_n)
    else $error("comparator alert did not clear");
  intr_hold_a: assert property (intr_reg && !cfg_clear |=> intr_reg) // R04
    else $error("interrupt dropped without clear");
  intr_clear_a: assert property (cfg_clear && !intr_set |=> !intr_reg) // R04
    else $error("interrupt clear ignored");
  crit_alarm_a: assert property ( // R07
    (sample && t_ext > $signed({crit_reg[12], crit_reg[12:0]}) && alert_en && !sensor_off
     && !wr_evt ##1 !wr_evt) |-> s_pin_low)
    else $error("critical alarm not asserted");
  crit_flag_a: assert property ( // R07
    sample && t_ext > $signed({crit_reg[12], crit_reg[12:0]}) |-> s_flags_set)
    else $error("critical flag not set");
  hys_hold_a: assert property ( // R22
    sample && over_hi_reg &&
    t_ext >= $signed({high_reg[12], high_reg[12:0]}) - $signed(hys_amt) |=> over_hi_reg)
    else $error("upper flag cleared inside hysteresis band");
  off_quiet_a: assert property (sensor_off |=> o_alert_oe_n && $stable(temp_reg)) // R23
    else $error("alert or temperature active in shutdown");
  ro_write_a: assert property ( // R12
    wr_evt && ptr_reg != tsra_pkg::PTR_CFG |=> $stable(cfg_reg))
    else $error("settings changed by foreign write");
  bus_tout_a: assert property (tout_hit |=> frame_clr_reg ##1 o_sda_oe_n) // R17
    else $error("timeout did not release serial link");

endmodule

/* sim/tsra_i2c_master.sv */
// Two-wire bus master model for the sensor block, driving clock and data.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/100ps

module tsra_i2c_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // ----
  // Bit and frame tasks
  // ----
  int nack_cnt = 0;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Data changes only while the clock is low, one 6 ns period per bit.
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    #2 o_scl = 1'b1;
    #3 r = i_sda;
    o_scl = 1'b0;
    #1;
  endtask
  task automatic bytex(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic r);
    logic t;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], t);
      q[i] = t;
    end
    bitx(a, r);
  endtask
  task automatic frame_start;
    @(negedge i_clk);
    o_sda = 1'b1;
    #2 o_scl = 1'b1;
    #200 o_sda = 1'b0;
    #200 o_scl = 1'b0;
    #200;
  endtask
  task automatic frame_stop;
    o_sda = 1'b0;
    #2 o_scl = 1'b1;
    #200 o_sda = 1'b1;
    #200;
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic r;
    bytex(d, 1'b1, q, r);
    if (r !== 1'b0) nack_cnt++;
  endtask
  // Callers never pass a reserved select here.
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] v);
    frame_start;
    send(8'h30);
    send(p);
    send(v[15:8]);
    send(v[7:0]);
    frame_stop;
  endtask
  task automatic rd_cur(output logic [15:0] v);
    logic r;
    frame_start;
    send(8'h31);
    bytex(8'hFF, 1'b0, v[15:8], r);
    bytex(8'hFF, 1'b1, v[7:0], r);
    frame_stop;
  endtask
  task automatic rd_reg(input logic [7:0] p, output logic [15:0] v);
    frame_start;
    send(8'h30);
    send(p);
    rd_cur(v);
  endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the sensor register block and its alert pin.
// Assumes short conversion and timeout counts set through parameters.
`timescale 1ns/100ps

module tb_top;
  // ----
  // Bench
  // ----
  localparam int CV = 200;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [11:0] code = 12'h010;
  logic scl, sda_m, sda_o, sda_oe_n, alert_o, alert_oe_n;
  wire sda = sda_m & (sda_oe_n | sda_o);
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 32'h4AB7;
  logic [15:0] mdl [0:15];
  logic [15:0] q;
  always #20 i_clk = ~i_clk;
  tsra_top #(.CONV_CYCLES(CV), .TIMEOUT_CYCLES(300)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_addr_strap(3'h0),
    .i_sensor_code(code), .o_alert_o(alert_o), .o_alert_oe_n(alert_oe_n));
  tsra_i2c_master master (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] p, input logic [15:0] v);
    master.wr_reg(p, v);
    if (p >= 8'h01 && p <= 8'h04) mdl[p] = (p == 8'h01) ? (v & 16'h07CF) : v;
  endtask
  task automatic get(input logic [7:0] p);
    master.rd_reg(p, q);
    check(q, mdl[p]);
  endtask
  // Two periods guarantee at least one sample whatever the phase.
  task automatic conv;
    repeat (2 * CV + 8) @(negedge i_clk);
  endtask
  task automatic alert_is(input logic lvl);
    check({14'h0000, alert_o, alert_oe_n}, {15'h0000, lvl});
  endtask
  initial begin
    for (int i = 0; i < 16; i++) mdl[i] = 16'h0000;
    mdl[0] = 16'h00F7;
    mdl[6] = tsra_pkg::MAKER_CODE_DEFAULT;
    mdl[7] = tsra_pkg::PART_CODE_DEFAULT;
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (8) @(negedge i_clk);
    master.rd_cur(q);
    check(q, 16'h00F7);
    put(8'h00, 16'h1234);
    put(8'h07, 16'hFFFF);
    check(16'(master.nack_cnt), 16'h0000);
    for (int p = 0; p < 10; p++) begin
      if (p != 5) get(p[7:0]);
    end
    put(8'h01, 16'hFFFF);
    get(8'h01);
    put(8'h01, 16'h0000);
    repeat (4) begin
      code = 12'($random(seed));
      if (code == 12'h000) code = 12'h001;
      conv;
      mdl[5] = {($signed(code) > 0) ? 3'b110 : 3'b001, code, 1'b0};
      get(8'h05);
    end
    @(negedge i_clk);
    code = 12'h010;
    put(8'h01, 16'h0008);
    conv;
    alert_is(1'b0);
    put(8'h02, 16'h0FF0);
    put(8'h04, 16'h0FF0);
    conv;
    alert_is(1'b1);
    put(8'h01, 16'h0009);
    conv;
    alert_is(1'b1);
    put(8'h02, 16'h0000);
    conv;
    alert_is(1'b0);
    put(8'h02, 16'h0FF0);
    conv;
    alert_is(1'b0);
    put(8'h01, 16'h0029);
    repeat (8) @(negedge i_clk);
    alert_is(1'b1);
    put(8'h01, 16'h0008);
    put(8'h02, 16'h0000);
    conv;
    alert_is(1'b0);
    mdl[5] = 16'h4020;
    get(8'h05);
    put(8'h02, 16'h0010);
    put(8'h01, 16'h0208);
    @(negedge i_clk);
    code = 12'h001;
    conv;
    mdl[5] = 16'h4002;
    get(8'h05);
    alert_is(1'b0);
    code = 12'h010;
    conv;
    mdl[5] = 16'h4020;
    put(8'h01, 16'h0108);
    repeat (8) @(negedge i_clk);
    alert_is(1'b1);
    code = 12'h7F0;
    conv;
    get(8'h05);
    master.frame_start;
    master.send(8'h31);
    repeat (8) @(negedge i_clk);
    check({15'h0000, sda}, 16'h0000);
    repeat (400) @(negedge i_clk);
    check({15'h0000, sda}, 16'h0001);
    master.frame_stop;
    get(8'h05);
    close_out;
  end
endmodule
